// ### bench/test_timer8_two_compare_pwm.sv
// Self-checking bench for the 8-bit two-compare timer.
// Assumes the checker and the pin model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_timer8_two_compare_pwm;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ack_a = 1'b0, port_a = 1'b0, go = 1'b0;
  logic [3:0] addr_i = 4'h0, pulses = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, count_value_o, v, c0;
  logic pin, busy, pin_a_o, irq_ovf, irq_a, hi;
  logic port_b = 1'b0, dir_a = 1'b1;
  logic pin_b_o, pin_a_oe, pin_b_oe, irq_b;
  int errors = 0, cmp_count = 0, cycles = 0, k;
  logic [7:0] om_t[4] = '{8'hC0, 8'h80, 8'h40, 8'h00};
  logic [7:0] ex_t[4] = '{8'h01, 8'h00, 8'h01, 8'h01};
  tmr8_timer tmr8_timer_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ack_overflow_i(1'b0), .ack_match_a_i(ack_a),
    .ack_match_b_i(1'b0), .ext_count_pin_i(pin), .port_a_value_i(port_a), .port_b_value_i(port_b),
    .out_pin_direction_a_i(dir_a), .out_pin_direction_b_i(1'b1), .pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe),
    .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe), .irq_overflow_o(irq_ovf), .irq_match_a_o(irq_a),
    .irq_match_b_o(irq_b), .count_value_o(count_value_o));
  tmr8_pin_model tmr8_pin_model_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .go_i(go), .pulses_i(pulses),
    .pin_o(pin), .busy_o(busy));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================================
  // Access tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    chk(v & m, exp);
  endtask
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rchk(4'h7, 8'hFF, 8'h01);
    rchk(4'hA, 8'h03, 8'h00);
    rchk(4'hF, 8'hFF, 8'h00);
    // With output modes off both pins follow the port values; direction passes through.
    @(posedge sys_clk_i);
    port_a <= 1'b1;
    port_b <= 1'b1;
    dir_a <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk({6'h00, pin_a_o, pin_b_o}, 8'h03);
    chk({6'h00, pin_a_oe, pin_b_oe}, 8'h01);
    @(posedge sys_clk_i);
    port_a <= 1'b0;
    port_b <= 1'b0;
    dir_a <= 1'b1;
    wr(4'h7, 8'h00);
    wr(4'h5, 8'h03);
    wr(4'h2, 8'hFD);
    wr(4'h1, 8'h01);
    for (k = 0; k < 40 && irq_ovf !== 1'b1; k++) @(posedge sys_clk_i);
    wr(4'h1, 8'h00);
    chk({7'h00, irq_ovf}, 8'h01);
    rchk(4'h6, 8'h01, 8'h01);
    wr(4'h6, 8'h01);
    rchk(4'h6, 8'h01, 8'h00);
    wr(4'h2, 8'h40);
    repeat (5) @(posedge sys_clk_i);
    rchk(4'h2, 8'hFF, 8'h40);
    wr(4'h0, 8'h42);
    wr(4'h3, 8'h05);
    wr(4'h2, 8'h00);
    wr(4'h6, 8'h07);
    wr(4'h1, 8'h01);
    hi = 1'b0;
    repeat (40) begin
      @(posedge sys_clk_i);
      #1 if ((count_value_o <= 8'h05) !== 1'b1) hi = 1'b1;
    end
    chk({7'h00, hi}, 8'h00);
    wr(4'h1, 8'h00);
    chk({7'h00, irq_a}, 8'h01);
    rchk(4'h6, 8'h02, 8'h02);
    @(posedge sys_clk_i);
    ack_a <= 1'b1;
    @(posedge sys_clk_i);
    ack_a <= 1'b0;
    rchk(4'h6, 8'h02, 8'h00);
    c0 = count_value_o;
    for (k = 0; k < 4; k++) begin
      wr(4'h0, om_t[k]);
      wr(4'h1, 8'h80);
      rchk(4'hA, 8'h01, ex_t[k]);
    end
    rchk(4'h6, 8'h02, 8'h00);
    rchk(4'h2, 8'hFF, c0);
    wr(4'h0, 8'hC0);
    repeat (3) @(posedge sys_clk_i);
    chk({7'h00, pin_a_o}, 8'h01);
    wr(4'h0, 8'hC3);
    rchk(4'hA, 8'h01, 8'h01);
    wr(4'h3, 8'h80);
    rchk(4'h8, 8'hFF, 8'h05);
    rchk(4'h3, 8'hFF, 8'h80);
    wr(4'h1, 8'h01);
    repeat (300) @(posedge sys_clk_i);
    wr(4'h1, 8'h00);
    rchk(4'h8, 8'hFF, 8'h80);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h33);
    rchk(4'h8, 8'hFF, 8'h33);
    wr(4'h4, 8'h10);
    wr(4'h2, 8'h10);
    wr(4'h6, 8'h07);
    wr(4'h1, 8'h01);
    repeat (8) @(posedge sys_clk_i);
    wr(4'h1, 8'h00);
    rchk(4'h6, 8'h04, 8'h00);
    wr(4'h2, 8'h0E);
    wr(4'h1, 8'h01);
    repeat (8) @(posedge sys_clk_i);
    wr(4'h1, 8'h00);
    rchk(4'h6, 8'h04, 8'h04);
    chk({7'h00, irq_b}, 8'h00);
    for (k = 7; k >= 6; k--) begin
      wr(4'h2, 8'h00);
      wr(4'h1, k[7:0]);
      repeat (3) @(posedge sys_clk_i);
      go <= 1'b1;
      pulses <= 4'h4;
      @(posedge sys_clk_i);
      go <= 1'b0;
      @(posedge sys_clk_i);
      for (int j = 0; j < 40 && busy !== 1'b0; j++) @(posedge sys_clk_i);
      repeat (6) @(posedge sys_clk_i);
      wr(4'h1, 8'h00);
      rchk(4'h2, 8'hFF, 8'h04);
    end
    wr(4'h0, 8'h01);
    wr(4'h2, 8'hF0);
    wr(4'h1, 8'h01);
    repeat (40) @(posedge sys_clk_i);
    wr(4'h1, 8'h00);
    rchk(4'h2, 8'hF0, 8'hE0);
    // Single slope with compare A as TOP must never pass 0x33.
    wr(4'h0, 8'h03);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h09);
    hi = 1'b0;
    repeat (60) begin
      @(posedge sys_clk_i);
      #1 if ((count_value_o <= 8'h33) !== 1'b1) hi = 1'b1;
    end
    wr(4'h1, 8'h00);
    chk({7'h00, hi}, 8'h00);
    finish_test();
  end
endmodule
bind tmr8_timer tmr8_timer_asserts tmr8_timer_asserts_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .port_a_value_i(port_a_value_i), .out_pin_direction_a_i(out_pin_direction_a_i), .pin_a_o(pin_a_o),
  .pin_a_oe_o(pin_a_oe_o), .irq_overflow_o(irq_overflow_o), .irq_match_a_o(irq_match_a_o),
  .count_value_o(count_value_o));
`default_nettype wire

// ### bench/tmr8_pin_model.sv
// Source on the external count pin: bursts of pulses, three cycles high, three low.
// Assumes the start strobe is one cycle long; the pin rests low between bursts.
`timescale 1ns/1ps
`default_nettype none
module tmr8_pin_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic go_i,
  input wire logic [3:0] pulses_i,
  // Pin
  output logic pin_o,
  output logic busy_o
);
  logic [6:0] left;
  always @(posedge sys_clk_i) begin
    if (reset_i) left <= 7'h00;
    else if (go_i) left <= pulses_i * 7'd6;
    else if (left != 7'h00) left <= left - 7'h01;
  end
  // Half periods exceed one system cycle so the sampler sees every edge.
  assign pin_o = (left != 7'h00) && (left % 7'd6 >= 7'd3);
  assign busy_o = left != 7'h00;
endmodule
`default_nettype wire

// ### bench/tmr8_timer_asserts.sv
// Checker for the 8-bit timer top: register port, pin override, interrupt masking.
// Assumes it is bound to tmr8_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_asserts (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pins, requests and counter value
  input wire logic port_a_value_i,
  input wire logic out_pin_direction_a_i,
  input wire logic pin_a_o,
  input wire logic pin_a_oe_o,
  input wire logic irq_overflow_o,
  input wire logic irq_match_a_o,
  input wire logic [7:0] count_value_o
);
  // ==========================================================================
  // Shadow registers
  logic [7:0] ctl_a, ctl_b, msk;
  logic pwr;
  logic [1:0] q_cs, q_pw;
  wire wr_cnt = wr_i && clk_en_i && addr_i == 4'h2;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctl_a <= 8'h00;
      ctl_b <= 8'h00;
      msk <= 8'h00;
      pwr <= 1'b1;
    end else if (wr_i && clk_en_i) begin
      if (addr_i == 4'h0) ctl_a <= wdata_i;
      if (addr_i == 4'h1) ctl_b <= wdata_i;
      if (addr_i == 4'h5) msk <= wdata_i;
      if (addr_i == 4'h7) pwr <= wdata_i[0];
    end
  end
  // Cycles in a row with no counter write and either no timer clock source or the power off.
  always @(posedge sys_clk_i) begin
    if (reset_i || wr_cnt || ctl_b[2:0] != 3'h0) q_cs <= 2'h0;
    else if (q_cs != 2'h3) q_cs <= q_cs + 2'h1;
    if (reset_i || wr_cnt || !pwr) q_pw <= 2'h0;
    else if (q_pw != 2'h3) q_pw <= q_pw + 2'h1;
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  property p_rd_idle; !$past(reset_i) && !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  property p_rd_count; !$past(reset_i) && $past(rd_i && addr_i == 4'h2) |-> rdata_o == $past(count_value_o); endproperty
  a_rd_count: assert property (p_rd_count) else $error("counter read mismatch");
  property p_wr_count; !$past(reset_i) && $past(wr_cnt) |-> count_value_o == $past(wdata_i); endproperty
  a_wr_count: assert property (p_wr_count) else $error("counter write lost");
  property p_halt; q_cs == 2'h3 |-> $stable(count_value_o); endproperty
  a_halt: assert property (p_halt) else $error("counter moved with no clock source");
  property p_power; q_pw == 2'h3 |-> $stable(count_value_o); endproperty
  a_power: assert property (p_power) else $error("counter moved while powered off");
  property p_oe; !$past(reset_i) |-> pin_a_oe_o == $past(out_pin_direction_a_i); endproperty
  a_oe: assert property (p_oe) else $error("pin direction not from port");
  property p_pin_port; !$past(reset_i) && $past(ctl_a[7:6]) == 2'h0 |-> pin_a_o == $past(port_a_value_i); endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin overridden with output mode off");
  property p_irq_ovf; irq_overflow_o |-> $past(msk[0]); endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request while masked");
  property p_irq_a; irq_match_a_o |-> $past(msk[1]); endproperty
  a_irq_a: assert property (p_irq_a) else $error("match A request while masked");
endmodule
`default_nettype wire

// ### hw/tmr8_clk_sel.v
// Timer clock selection: prescaler taps and synchronised external pin edges.
// Assumes the pin input is synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defines.vh"
module tmr8_clk_sel (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  input wire clk_en_i,
  // Control
  input wire run_i,
  input wire [2:0] clock_select_i,
  input wire ext_count_pin_i,
  // Result
  output reg timer_clock_o
);
  reg [9:0] prescale;
  reg pin_s1;
  reg pin_s2;
  reg pin_s3;
  reg next_tick;

  always @* begin
    next_tick = 1'b0;
    case (clock_select_i)
      3'h1: next_tick = 1'b1;
      3'h2: next_tick = (prescale[2:0] == 3'h7);
      3'h3: next_tick = (prescale[5:0] == 6'h3F);
      3'h4: next_tick = (prescale[7:0] == 8'hFF);
      3'h5: next_tick = (prescale == 10'h3FF);
      `TMR8_CS_FALL: next_tick = pin_s3 & ~pin_s2;
      `TMR8_CS_RISE: next_tick = pin_s2 & ~pin_s3;
      default: next_tick = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      prescale <= 10'h000;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      timer_clock_o <= 1'b0;
    end else if (clk_en_i) begin
      prescale <= prescale + 10'h001;
      pin_s1 <= ext_count_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      timer_clock_o <= run_i & next_tick;
    end
  end
endmodule
`default_nettype wire

// ### hw/tmr8_cmp_unit.v
// One compare unit: double-buffered compare value and compare output register.
// Assumes the top supplies timer-clock strobes, match blocking and mode decode.
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defines.vh"
module tmr8_cmp_unit (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  input wire clk_en_i,
  // Software access
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire force_i,
  input wire [1:0] out_mode_i,
  // Counter state
  input wire tick_i,
  input wire [7:0] count_value_i,
  input wire block_i,
  input wire pwm_i,
  input wire update_i,
  input wire at_bottom_i,
  input wire at_top_i,
  input wire down_i,
  input wire dual_i,
  // Results
  output reg [7:0] buffer_o,
  output reg [7:0] active_o,
  output wire match_o,
  output reg compare_out_o
);
  reg next_out;

  // Comparator runs on the active register except while block_i is set after a counter write.
  assign match_o = (count_value_i == active_o) & ~block_i;

  always @* begin
    next_out = compare_out_o;
    if (force_i && !pwm_i) begin
      case (out_mode_i)
        `TMR8_OM_TOGGLE: next_out = ~compare_out_o;
        `TMR8_OM_CLEAR: next_out = 1'b0;
        `TMR8_OM_SET: next_out = 1'b1;
        default: next_out = compare_out_o;
      endcase
    end else if (tick_i && !pwm_i && match_o) begin
      case (out_mode_i)
        `TMR8_OM_TOGGLE: next_out = ~compare_out_o;
        `TMR8_OM_CLEAR: next_out = 1'b0;
        `TMR8_OM_SET: next_out = 1'b1;
        default: next_out = compare_out_o;
      endcase
    end else if (tick_i && pwm_i && out_mode_i[1]) begin
      if (match_o) begin
        next_out = dual_i ? (down_i ^ ~out_mode_i[0]) : out_mode_i[0];
      end else if (at_bottom_i && !dual_i) begin
        next_out = ~out_mode_i[0];
      end
    end else if (tick_i && pwm_i && out_mode_i == `TMR8_OM_TOGGLE && match_o) begin
      next_out = ~compare_out_o;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      buffer_o <= `TMR8_RST_BYTE;
      active_o <= `TMR8_RST_BYTE;
      compare_out_o <= 1'b0;
    end else if (clk_en_i) begin
      compare_out_o <= next_out;
      if (wr_i) begin
        buffer_o <= wdata_i;
      end
      if (wr_i && !pwm_i) begin
        active_o <= wdata_i;
      end else if (pwm_i && tick_i && update_i && (at_top_i || at_bottom_i)) begin
        active_o <= buffer_o;
      end else if (!pwm_i) begin
        active_o <= buffer_o;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/tmr8_timer.v
// Top of the 8-bit timer/counter with two compare units and PWM outputs.
// Assumes a single-cycle register port and synchronous port pins.
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defines.vh"
module tmr8_timer (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  input wire clk_en_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Interrupt service acknowledges
  input wire ack_overflow_i,
  input wire ack_match_a_i,
  input wire ack_match_b_i,
  // Pins
  input wire ext_count_pin_i,
  input wire port_a_value_i,
  input wire port_b_value_i,
  input wire out_pin_direction_a_i,
  input wire out_pin_direction_b_i,
  output reg pin_a_o,
  output reg pin_a_oe_o,
  output reg pin_b_o,
  output reg pin_b_oe_o,
  // Interrupt requests and counter value
  output reg irq_overflow_o,
  output reg irq_match_a_o,
  output reg irq_match_b_o,
  output reg [7:0] count_value_o
);
  // ==========================================================================
  // Registers
  localparam ST_UP = 2'b01;
  localparam ST_DOWN = 2'b10;
  reg [7:0] control_a_reg;
  reg [7:0] control_b_reg;
  reg [7:0] count_value;
  reg [2:0] irq_flag_reg;
  reg [2:0] irq_mask_reg;
  reg module_power_off;
  reg block_pending;
  reg [1:0] dir_state;
  reg [7:0] next_count;
  reg [1:0] next_dir;
  reg next_ovf;
  reg [2:0] next_flags;
  reg [7:0] next_rdata;
  wire [2:0] wave_mode;
  wire [1:0] out_mode_a;
  wire [1:0] out_mode_b;
  wire timer_clock;
  wire tick;
  wire pwm;
  wire dual;
  wire top_is_a;
  wire [7:0] top_value;
  wire at_bottom;
  wire at_max;
  wire at_top;
  wire block;
  wire match_a;
  wire match_b;
  wire out_a;
  wire out_b;
  wire [7:0] buf_a;
  wire [7:0] buf_b;
  wire [7:0] act_a;
  wire [7:0] act_b;
  wire wr_cnt;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire wr_flag;
  wire force_a;
  wire force_b;

  // ==========================================================================
  // Decode
  assign wave_mode = {control_b_reg[`TMR8_CB_WM2], control_a_reg[`TMR8_CA_WM1],
                      control_a_reg[`TMR8_CA_WM0]};
  assign out_mode_a = control_a_reg[`TMR8_CA_OMA_HI:`TMR8_CA_OMA_LO];
  assign out_mode_b = control_a_reg[`TMR8_CA_OMB_HI:`TMR8_CA_OMB_LO];
  assign pwm = control_a_reg[`TMR8_CA_WM0] | control_a_reg[`TMR8_CA_WM1] & control_b_reg[`TMR8_CB_WM2];
  assign dual = (wave_mode == `TMR8_WM_PCPWM) || (wave_mode == `TMR8_WM_PCPWM_A);
  assign top_is_a = (wave_mode == `TMR8_WM_CTC) || (wave_mode == `TMR8_WM_FAST_A) ||
                    (wave_mode == `TMR8_WM_PCPWM_A);
  assign top_value = top_is_a ? act_a : `TMR8_MAX;
  assign at_bottom = (count_value == `TMR8_BOTTOM);
  assign at_max = (count_value == `TMR8_MAX);
  assign at_top = (count_value == top_value);
  assign tick = timer_clock & clk_en_i;
  assign block = block_pending;
  assign wr_cnt = wr_i && addr_i == `TMR8_OFS_COUNT;
  assign wr_cmp_a = wr_i && addr_i == `TMR8_OFS_CMP_A;
  assign wr_cmp_b = wr_i && addr_i == `TMR8_OFS_CMP_B;
  assign wr_flag = wr_i && addr_i == `TMR8_OFS_FLAG;
  assign force_a = wr_i && addr_i == `TMR8_OFS_CTRL_B && wdata_i[`TMR8_CB_FOCA];
  assign force_b = wr_i && addr_i == `TMR8_OFS_CTRL_B && wdata_i[`TMR8_CB_FOCB];

  // ==========================================================================
  // Timer clock
  tmr8_clk_sel u_clk (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .run_i(~module_power_off),
    .clock_select_i(control_b_reg[`TMR8_CB_CS_HI:`TMR8_CB_CS_LO]),
    .ext_count_pin_i(ext_count_pin_i),
    .timer_clock_o(timer_clock)
  );

  // ==========================================================================
  // Compare units
  tmr8_cmp_unit u_cmp_a (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_cmp_a),
    .wdata_i(wdata_i),
    .force_i(force_a),
    .out_mode_i(out_mode_a),
    .tick_i(tick),
    .count_value_i(count_value),
    .block_i(block),
    .pwm_i(pwm),
    .update_i(1'b1),
    .at_bottom_i(at_bottom),
    .at_top_i(at_top),
    .down_i(dir_state == ST_DOWN),
    .dual_i(dual),
    .buffer_o(buf_a),
    .active_o(act_a),
    .match_o(match_a),
    .compare_out_o(out_a)
  );

  tmr8_cmp_unit u_cmp_b (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_cmp_b),
    .wdata_i(wdata_i),
    .force_i(force_b),
    .out_mode_i(out_mode_b),
    .tick_i(tick),
    .count_value_i(count_value),
    .block_i(block),
    .pwm_i(pwm),
    .update_i(1'b1),
    .at_bottom_i(at_bottom),
    .at_top_i(at_top),
    .down_i(dir_state == ST_DOWN),
    .dual_i(dual),
    .buffer_o(buf_b),
    .active_o(act_b),
    .match_o(match_b),
    .compare_out_o(out_b)
  );

  // ==========================================================================
  // Counter sequence
  always @* begin
    next_count = count_value;
    next_dir = dir_state;
    next_ovf = 1'b0;
    if (tick) begin
      if (dual) begin
        // Dual slope turns round at both ends; overflow at BOTTOM.
        case (dir_state)
          ST_UP: begin
            if (at_top) begin
              next_dir = ST_DOWN;
              next_count = count_value - 8'h01;
            end else begin
              next_count = count_value + 8'h01;
            end
          end
          ST_DOWN: begin
            if (at_bottom) begin
              next_dir = ST_UP;
              next_count = count_value + 8'h01;
              next_ovf = 1'b1;
            end else begin
              next_count = count_value - 8'h01;
            end
          end
          default: next_dir = ST_UP;
        endcase
      end else if (wave_mode == `TMR8_WM_CTC) begin
        next_count = match_a ? `TMR8_BOTTOM : count_value + 8'h01;
        next_ovf = at_max;
      end else if (wave_mode == `TMR8_WM_FAST || wave_mode == `TMR8_WM_FAST_A) begin
        next_count = at_top ? `TMR8_BOTTOM : count_value + 8'h01;
        next_ovf = at_top;
      end else begin
        next_count = count_value + 8'h01;
        next_ovf = at_max;
      end
    end
    if (wr_cnt) begin
      next_count = wdata_i;
    end
  end

  // Hardware sets win over software and service clears.
  always @* begin
    next_flags = irq_flag_reg;
    if (wr_flag) begin
      next_flags = irq_flag_reg & ~wdata_i[2:0];
    end
    if (ack_overflow_i) begin
      next_flags[`TMR8_FL_OVF] = 1'b0;
    end
    if (ack_match_a_i) begin
      next_flags[`TMR8_FL_MA] = 1'b0;
    end
    if (ack_match_b_i) begin
      next_flags[`TMR8_FL_MB] = 1'b0;
    end
    if (next_ovf) begin
      next_flags[`TMR8_FL_OVF] = 1'b1;
    end
    if (tick && match_a) begin
      next_flags[`TMR8_FL_MA] = 1'b1;
    end
    if (tick && match_b) begin
      next_flags[`TMR8_FL_MB] = 1'b1;
    end
  end

  // ==========================================================================
  // Read mux
  always @* begin
    case (addr_i)
      `TMR8_OFS_CTRL_A: next_rdata = control_a_reg;
      `TMR8_OFS_CTRL_B: next_rdata = {2'b00, control_b_reg[5:0]};
      `TMR8_OFS_COUNT: next_rdata = count_value;
      `TMR8_OFS_CMP_A: next_rdata = pwm ? buf_a : act_a;
      `TMR8_OFS_CMP_B: next_rdata = pwm ? buf_b : act_b;
      `TMR8_OFS_MASK: next_rdata = {5'h00, irq_mask_reg};
      `TMR8_OFS_FLAG: next_rdata = {5'h00, irq_flag_reg};
      `TMR8_OFS_POWER: next_rdata = {7'h00, module_power_off};
      `TMR8_OFS_ACTIVE_A: next_rdata = act_a;
      `TMR8_OFS_ACTIVE_B: next_rdata = act_b;
      `TMR8_OFS_OUT: next_rdata = {6'h00, out_b, out_a};
      default: next_rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // State
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      control_a_reg <= `TMR8_RST_BYTE;
      control_b_reg <= `TMR8_RST_BYTE;
      count_value <= `TMR8_RST_BYTE;
      irq_flag_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      module_power_off <= `TMR8_RST_POWER;
      block_pending <= 1'b0;
      dir_state <= ST_UP;
      rdata_o <= 8'h00;
      pin_a_o <= 1'b0;
      pin_a_oe_o <= 1'b0;
      pin_b_o <= 1'b0;
      pin_b_oe_o <= 1'b0;
      irq_overflow_o <= 1'b0;
      irq_match_a_o <= 1'b0;
      irq_match_b_o <= 1'b0;
      count_value_o <= 8'h00;
    end else if (clk_en_i) begin
      if (wr_i && addr_i == `TMR8_OFS_CTRL_A) begin
        control_a_reg <= wdata_i;
      end
      if (wr_i && addr_i == `TMR8_OFS_CTRL_B) begin
        control_b_reg <= {2'b00, wdata_i[5:0]}; // Force strobes read as zero.
      end
      if (wr_i && addr_i == `TMR8_OFS_MASK) begin
        irq_mask_reg <= wdata_i[2:0];
      end
      if (wr_i && addr_i == `TMR8_OFS_POWER) begin
        module_power_off <= wdata_i[0];
      end
      count_value <= next_count;
      dir_state <= next_dir;
      irq_flag_reg <= next_flags;
      // Blocking lasts until the next timer clock is consumed.
      if (wr_cnt) begin
        block_pending <= 1'b1;
      end else if (tick) begin
        block_pending <= 1'b0;
      end
      rdata_o <= rd_i ? next_rdata : 8'h00;
      pin_a_o <= (out_mode_a != `TMR8_OM_OFF) ? out_a : port_a_value_i;
      pin_b_o <= (out_mode_b != `TMR8_OM_OFF) ? out_b : port_b_value_i;
      pin_a_oe_o <= out_pin_direction_a_i;
      pin_b_oe_o <= out_pin_direction_b_i;
      irq_overflow_o <= next_flags[`TMR8_FL_OVF] & irq_mask_reg[`TMR8_FL_OVF];
      irq_match_a_o <= next_flags[`TMR8_FL_MA] & irq_mask_reg[`TMR8_FL_MA];
      irq_match_b_o <= next_flags[`TMR8_FL_MB] & irq_mask_reg[`TMR8_FL_MB];
      count_value_o <= next_count;
    end
  end
endmodule
`default_nettype wire

// ### pkg/tmr8_defines.vh
// Constants of the 8-bit two-compare timer: register offsets, field positions, resets.
// Assumes inclusion by bare name from the design files.
`ifndef TMR8_DEFINES_VH
`define TMR8_DEFINES_VH
// ==========================================================================
// Register offsets
`define TMR8_OFS_CTRL_A 4'h0
`define TMR8_OFS_CTRL_B 4'h1
`define TMR8_OFS_COUNT 4'h2
`define TMR8_OFS_CMP_A 4'h3
`define TMR8_OFS_CMP_B 4'h4
`define TMR8_OFS_MASK 4'h5
`define TMR8_OFS_FLAG 4'h6
`define TMR8_OFS_POWER 4'h7
`define TMR8_OFS_ACTIVE_A 4'h8
`define TMR8_OFS_ACTIVE_B 4'h9
`define TMR8_OFS_OUT 4'hA
// ==========================================================================
// Field positions
`define TMR8_CA_WM0 0
`define TMR8_CA_WM1 1
`define TMR8_CA_OMB_LO 4
`define TMR8_CA_OMB_HI 5
`define TMR8_CA_OMA_LO 6
`define TMR8_CA_OMA_HI 7
`define TMR8_CB_CS_LO 0
`define TMR8_CB_CS_HI 2
`define TMR8_CB_WM2 3
`define TMR8_CB_FOCB 6
`define TMR8_CB_FOCA 7
`define TMR8_FL_OVF 0
`define TMR8_FL_MA 1
`define TMR8_FL_MB 2
// ==========================================================================
// Values and resets
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hFF
`define TMR8_RST_BYTE 8'h00
`define TMR8_RST_POWER 1'b1
`define TMR8_CS_OFF 3'h0
`define TMR8_CS_FALL 3'h6
`define TMR8_CS_RISE 3'h7
`define TMR8_WM_NORMAL 3'h0
`define TMR8_WM_PCPWM 3'h1
`define TMR8_WM_CTC 3'h2
`define TMR8_WM_FAST 3'h3
`define TMR8_WM_PCPWM_A 3'h5
`define TMR8_WM_FAST_A 3'h7
`define TMR8_OM_OFF 2'h0
`define TMR8_OM_TOGGLE 2'h1
`define TMR8_OM_CLEAR 2'h2
`define TMR8_OM_SET 2'h3
`endif
